/* File: include/pira_consts.vh */
// Constants for the indirect PHY register access bridge.
// Included by the bridge top and its access state machine.
`ifndef PIRA_CONSTS_VH
`define PIRA_CONSTS_VH

// Register indices; the byte address is four times the index
`define PIRA_IDX_DATA 16'hD100
`define PIRA_IDX_ADDR 16'hD101
`define PIRA_IDX_CTRL 16'hD102
`define PIRA_IDX_WDT_CTRL 16'hD111
`define PIRA_IDX_WDT_PERIOD 16'hD112
`define PIRA_IDX_INT_STATUS 16'hD120
`define PIRA_IDX_INT_CLEAR 16'hD121
`define PIRA_IDX_INT_ENABLE 16'hD122

// Reset values
`define PIRA_RST_DATA 16'h0000
`define PIRA_RST_ADDR 16'h0000
`define PIRA_RST_CTRL 16'h1000
`define PIRA_RST_WDT_CTRL 16'h0000
`define PIRA_RST_WDT_PERIOD 16'hFFFF

// Control register fields
`define PIRA_CTRL_STATUS 0
`define PIRA_CTRL_READ_GO 4
`define PIRA_CTRL_WRITE_GO 8
`define PIRA_CTRL_FSM_RST_N 12

// Watchdog control fields
`define PIRA_WDT_ERR 0
`define PIRA_WDT_EN 1

// Interrupt bits
`define PIRA_INT_DONE 0
`define PIRA_INT_WDT 1
`define PIRA_INT_W 2

// Bus widths and responses
`define PIRA_AXI_AW 18
`define PIRA_RESP_OKAY 2'b00
`define PIRA_RESP_SLVERR 2'b10

`endif

/* File: rtl/pira_access_fsm.v */
// Access state machine: runs one read or write on the PHY control port.
// Assumes the PHY port is on aclk and answers with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
`include "pira_consts.vh"

module pira_access_fsm #(
    parameter W = 16
) (
    // Clock and synchronous reset (bus reset or soft reset)
    input wire aclk,
    input wire fsm_rst_n,
    // Launch requests, accepted only when idle
    input wire launch_wr,
    input wire launch_rd,
    input wire [W-1:0] addr,
    input wire [W-1:0] wdata,
    // Watchdog
    input wire wdt_en,
    input wire [W-1:0] wdt_period,
    // State and events
    output reg busy,
    output reg busy_we,
    output reg done,
    output reg timeout,
    output reg rdata_valid,
    output reg [W-1:0] rdata,
    // PHY control port
    output reg phy_req,
    output reg phy_we,
    output reg [W-1:0] phy_addr,
    output reg [W-1:0] phy_wdata,
    input wire phy_ack,
    input wire [W-1:0] phy_rdata
);

    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    reg state;
    reg [W-1:0] wdt_cnt;

    always @(posedge aclk)
    begin
        done <= 1'b0;
        timeout <= 1'b0;
        rdata_valid <= 1'b0;
        if (!fsm_rst_n)
        begin
            state <= ST_IDLE;
            busy <= 1'b0;
            busy_we <= 1'b0;
            phy_req <= 1'b0;
            phy_we <= 1'b0;
            phy_addr <= {W{1'b0}};
            phy_wdata <= {W{1'b0}};
            rdata <= {W{1'b0}};
            wdt_cnt <= {W{1'b0}};
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    wdt_cnt <= {W{1'b0}};
                    if (launch_wr || launch_rd)
                    begin
                        state <= ST_BUSY;
                        busy <= 1'b1;
                        busy_we <= launch_wr;
                        phy_req <= 1'b1;
                        phy_we <= launch_wr;
                        phy_addr <= addr;
                        phy_wdata <= wdata;
                    end
                end
                ST_BUSY:
                begin
                    if (phy_ack)
                    begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        phy_req <= 1'b0;
                        done <= 1'b1;
                        if (!phy_we)
                        begin
                            rdata <= phy_rdata;
                            rdata_valid <= 1'b1;
                        end
                    end
                    else if (wdt_en && wdt_cnt >= wdt_period)
                    begin
                        // Abandon the access; a late ack is then ignored
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        phy_req <= 1'b0;
                        timeout <= 1'b1;
                    end
                    else if (wdt_en)
                    begin
                        wdt_cnt <= wdt_cnt + 1'b1;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                    phy_req <= 1'b0;
                end
            endcase
        end
    end

endmodule // pira_access_fsm

`default_nettype wire

/* File: rtl/pira_top.v */
// Indirect PHY register access bridge with an AXI4-Lite register slave.
// Assumes the PHY control port runs on aclk; one access outstanding.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pira_consts.vh"

// Behaviour
// - Completed read puts returned 16-bit value in the data register.
// - Address register holds target address and reads back as written.
// - Writing one to control bit 8 writes data to the held address.
// - Writing one to control bit 4 reads the address; bit self-clears.
// - Read-only status bit 0 clears when any transaction starts.
// - Status bit sets on completion, holds until reset or next start.
// - Control bit 12 low resets the access machine; control resets to 1000h.
// - Watchdog control bit 1 enables the watchdog; register resets to zero.
// - Watchdog period register is 16 bits, resets to FFFFh.
// - Watchdog control bit 0 is read-only error, set by watchdog reset.
module pira_top #(
    parameter AW = `PIRA_AXI_AW
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Interrupt
    output reg irq,
    // PHY control port
    output wire phy_req,
    output wire phy_we,
    output wire [15:0] phy_addr,
    output wire [15:0] phy_wdata,
    input wire phy_ack,
    input wire [15:0] phy_rdata
);

    // Registers
    reg [15:0] phy_access_data;
    reg [15:0] phy_access_address;
    reg access_fsm_rst_n;
    reg access_status;
    reg wdt_enable;
    reg wdt_error;
    reg [15:0] wdt_period;
    reg [`PIRA_INT_W-1:0] int_status;
    reg [`PIRA_INT_W-1:0] int_enable;

    // Bus holding registers
    reg [AW-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg [AW-1:0] ar_addr_q;

    // Access machine signals
    wire busy;
    wire busy_we;
    wire done;
    wire timeout;
    wire rdata_valid;
    wire [15:0] rdata;

    function known_idx;
        input [15:0] idx;
        begin
            case (idx)
                `PIRA_IDX_DATA, `PIRA_IDX_ADDR, `PIRA_IDX_CTRL,
                `PIRA_IDX_WDT_CTRL, `PIRA_IDX_WDT_PERIOD,
                `PIRA_IDX_INT_STATUS, `PIRA_IDX_INT_CLEAR,
                `PIRA_IDX_INT_ENABLE:
                    known_idx = 1'b1;
                default:
                    known_idx = 1'b0;
            endcase
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
            merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
        end
    endfunction

    // Both halves of a write are held; fires once, bvalid blocks a repeat
    wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire [15:0] wr_idx = aw_addr_q[17:2];
    wire wr_ctrl = wr_fire && wr_idx == `PIRA_IDX_CTRL;
    wire [15:0] ctrl_new = merge16({3'b000, access_fsm_rst_n, 12'h000}, w_data_q, w_strb_q);

    wire go_wr = wr_ctrl && w_strb_q[1] && w_data_q[`PIRA_CTRL_WRITE_GO];
    wire go_rd = wr_ctrl && w_strb_q[0] && w_data_q[`PIRA_CTRL_READ_GO];
    // Write wins when both triggers arrive together
    wire can_go = !busy && access_fsm_rst_n;
    wire launch_wr = go_wr && can_go;
    wire launch_rd = go_rd && !go_wr && can_go;
    wire launch = launch_wr || launch_rd;

    wire [15:0] rd_idx = ar_addr_q[17:2];
    wire [`PIRA_INT_W-1:0] int_events;
    wire [`PIRA_INT_W-1:0] int_clear;

    assign int_events = {timeout, done};
    assign int_clear = (wr_fire && wr_idx == `PIRA_IDX_INT_CLEAR && w_strb_q[0])
        ? w_data_q[`PIRA_INT_W-1:0] : {`PIRA_INT_W{1'b0}};

    // Write address and data channels, taken in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PIRA_RESP_OKAY;
            aw_addr_q <= {AW{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awready && s_axi_awvalid)
            begin
                s_axi_awready <= 1'b0;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wready && s_axi_wvalid)
            begin
                s_axi_wready <= 1'b0;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_idx(wr_idx) ? `PIRA_RESP_OKAY : `PIRA_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: answer one cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `PIRA_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            ar_addr_q <= {AW{1'b0}};
        end
        else
        begin
            if (s_axi_arready && s_axi_arvalid)
            begin
                s_axi_arready <= 1'b0;
                ar_addr_q <= s_axi_araddr;
            end
            if (!s_axi_arready && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_idx(rd_idx) ? `PIRA_RESP_OKAY : `PIRA_RESP_SLVERR;
                case (rd_idx)
                    `PIRA_IDX_DATA:
                        s_axi_rdata <= {16'h0000, phy_access_data};
                    `PIRA_IDX_ADDR:
                        s_axi_rdata <= {16'h0000, phy_access_address};
                    `PIRA_IDX_CTRL:
                        s_axi_rdata <= {19'h0, access_fsm_rst_n, 3'h0,
                            busy && busy_we, 3'h0, busy && !busy_we,
                            3'h0, access_status};
                    `PIRA_IDX_WDT_CTRL:
                        s_axi_rdata <= {30'h0, wdt_enable, wdt_error};
                    `PIRA_IDX_WDT_PERIOD:
                        s_axi_rdata <= {16'h0000, wdt_period};
                    `PIRA_IDX_INT_STATUS:
                        s_axi_rdata <= {30'h0, int_status};
                    `PIRA_IDX_INT_ENABLE:
                        s_axi_rdata <= {30'h0, int_enable};
                    default:
                        s_axi_rdata <= 32'h00000000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Reset words as vectors so that single fields can be picked out
    localparam [15:0] CTRL_RESET = `PIRA_RST_CTRL;
    localparam [15:0] WDT_CTRL_RESET = `PIRA_RST_WDT_CTRL;

    // Software-written registers
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            phy_access_data <= `PIRA_RST_DATA;
            phy_access_address <= `PIRA_RST_ADDR;
            access_fsm_rst_n <= CTRL_RESET[`PIRA_CTRL_FSM_RST_N];
            wdt_enable <= WDT_CTRL_RESET[`PIRA_WDT_EN];
            wdt_period <= `PIRA_RST_WDT_PERIOD;
            int_enable <= {`PIRA_INT_W{1'b0}};
        end
        else
        begin
            // Returned read data wins over a same-cycle software write
            if (rdata_valid)
                phy_access_data <= rdata;
            else if (wr_fire && wr_idx == `PIRA_IDX_DATA)
                phy_access_data <= merge16(phy_access_data, w_data_q, w_strb_q);
            if (wr_fire && wr_idx == `PIRA_IDX_ADDR)
                phy_access_address <= merge16(phy_access_address, w_data_q, w_strb_q);
            if (wr_ctrl)
                access_fsm_rst_n <= ctrl_new[`PIRA_CTRL_FSM_RST_N];
            if (wr_fire && wr_idx == `PIRA_IDX_WDT_CTRL && w_strb_q[0])
                wdt_enable <= w_data_q[`PIRA_WDT_EN];
            if (wr_fire && wr_idx == `PIRA_IDX_WDT_PERIOD)
                wdt_period <= merge16(wdt_period, w_data_q, w_strb_q);
            if (wr_fire && wr_idx == `PIRA_IDX_INT_ENABLE && w_strb_q[0])
                int_enable <= w_data_q[`PIRA_INT_W-1:0];
        end
    end

    // Hardware status flags
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            access_status <= 1'b0;
            wdt_error <= 1'b0;
            int_status <= {`PIRA_INT_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            if (launch)
                access_status <= 1'b0;
            else if (done)
                access_status <= 1'b1;
            if (launch)
                wdt_error <= 1'b0;
            else if (timeout)
                wdt_error <= 1'b1;
            // Set wins over a clear in the same cycle
            int_status <= (int_status & ~int_clear) | int_events;
            irq <= |(((int_status & ~int_clear) | int_events) & int_enable);
        end
    end

    // Soft reset holds the machine idle; a timeout idles it from inside
    wire fsm_rst_n = aresetn && access_fsm_rst_n;

    pira_access_fsm #(
        .W(16)
    ) u_access_fsm (
        .aclk(aclk),
        .fsm_rst_n(fsm_rst_n),
        .launch_wr(launch_wr),
        .launch_rd(launch_rd),
        .addr(phy_access_address),
        .wdata(phy_access_data),
        .wdt_en(wdt_enable),
        .wdt_period(wdt_period),
        .busy(busy),
        .busy_we(busy_we),
        .done(done),
        .timeout(timeout),
        .rdata_valid(rdata_valid),
        .rdata(rdata),
        .phy_req(phy_req),
        .phy_we(phy_we),
        .phy_addr(phy_addr),
        .phy_wdata(phy_wdata),
        .phy_ack(phy_ack),
        .phy_rdata(phy_rdata)
    );

endmodule // pira_top

`default_nettype wire

/* File: tb/phy_indirect_reg_access_test.sv */
// Self-checking bench for the PHY register bridge.
// Drives AXI4-Lite from the bench; a model answers on the PHY port.
`timescale 1ns/10ps
`default_nettype none
`include "pira_consts.vh"
module phy_indirect_reg_access_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata;
    logic phy_req, phy_we, phy_ack, mute = 1'b0;
    logic [15:0] phy_addr, phy_wdata, phy_rdata;
    logic [7:0] delay = 8'h14, count;
    int errors = 0, num_checks = 0;

    pira_top i_dut (.*);
    pira_phy_model i_phy (.*);

    always #4 aclk = ~aclk;

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        int n;
        n = 0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, val};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 1000);
        resp = s_axi_bresp;
        check("write answer", 32'h1, {31'h0, n < 1000});
    endtask

    task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
        int n;
        n = 0;
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 1000);
        resp = s_axi_rresp;
        check($sformatf("register %h", idx), exp, s_axi_rdata);
    endtask

    // Polls the status bit through the bus; quiet reads
    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            s_axi_araddr <= {16'(`PIRA_IDX_CTRL), 2'b00};
            s_axi_arvalid <= 1'b1;
            @(posedge aclk);
            while (s_axi_rvalid !== 1'b1 && n < 1000)
            begin
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                @(posedge aclk);
                n++;
            end
        end
        while (s_axi_rdata[0] !== 1'b1 && n < 1000);
        check("completion", 32'h1, {31'h0, n < 1000});
    endtask

    task automatic t_reset;
        rchk(`PIRA_IDX_DATA, 32'h0);
        rchk(`PIRA_IDX_ADDR, 32'h0);
        rchk(`PIRA_IDX_CTRL, 32'h1000);
        rchk(`PIRA_IDX_WDT_CTRL, 32'h0);
        rchk(`PIRA_IDX_WDT_PERIOD, 32'hFFFF);
        rchk(16'hD130, 32'h0);
        check("read resp", 32'h2, {30'h0, resp});
        wr(16'hD130, 16'h1234);
        check("write resp", 32'h2, {30'h0, resp});
    endtask

    task automatic t_access;
        wr(`PIRA_IDX_ADDR, 16'h0003);
        rchk(`PIRA_IDX_ADDR, 32'h0003);
        wr(`PIRA_IDX_DATA, 16'hBEEF);
        wr(`PIRA_IDX_CTRL, 16'h1100);
        wait_done();
        rchk(`PIRA_IDX_CTRL, 32'h1001);
        wr(`PIRA_IDX_DATA, 16'h0000);
        wr(`PIRA_IDX_CTRL, 16'h1010);
        rchk(`PIRA_IDX_CTRL, 32'h1010);
        wait_done();
        rchk(`PIRA_IDX_CTRL, 32'h1001);
        rchk(`PIRA_IDX_DATA, 32'hBEEF);
    endtask

    task automatic t_busy;
        logic [7:0] c0;
        c0 = count;
        delay <= 8'h1E;
        wr(`PIRA_IDX_CTRL, 16'h1010);
        wr(`PIRA_IDX_CTRL, 16'h1100);
        wait_done();
        check("accesses", {24'h0, c0 + 8'h01}, {24'h0, count});
        check("phy_req", 32'h0, {31'h0, phy_req});
    endtask

    task automatic t_watchdog;
        mute <= 1'b1;
        wr(`PIRA_IDX_WDT_PERIOD, 16'h0010);
        rchk(`PIRA_IDX_WDT_PERIOD, 32'h0010);
        wr(`PIRA_IDX_WDT_CTRL, 16'h0003);
        rchk(`PIRA_IDX_WDT_CTRL, 32'h0002);
        wr(`PIRA_IDX_CTRL, 16'h1010);
        // Period 16 expires after about 17 cycles
        repeat (40) @(posedge aclk);
        check("phy_req", 32'h0, {31'h0, phy_req});
        rchk(`PIRA_IDX_WDT_CTRL, 32'h0003);
        rchk(`PIRA_IDX_CTRL, 32'h1000);
        mute <= 1'b0;
        delay <= 8'h04;
    endtask

    task automatic t_irq;
        rchk(`PIRA_IDX_INT_STATUS, 32'h0003);
        check("irq", 32'h0, {31'h0, irq});
        wr(`PIRA_IDX_INT_ENABLE, 16'h0002);
        repeat (2) @(posedge aclk);
        check("irq", 32'h1, {31'h0, irq});
        wr(`PIRA_IDX_INT_CLEAR, 16'h0003);
        rchk(`PIRA_IDX_INT_STATUS, 32'h0);
        check("irq", 32'h0, {31'h0, irq});
        wr(`PIRA_IDX_INT_ENABLE, 16'h0001);
        wr(`PIRA_IDX_CTRL, 16'h1100);
        wait_done();
        repeat (2) @(posedge aclk);
        check("irq", 32'h1, {31'h0, irq});
    endtask

    task automatic t_soft;
        logic [7:0] c0;
        c0 = count;
        mute <= 1'b1;
        wr(`PIRA_IDX_CTRL, 16'h1010);
        wr(`PIRA_IDX_CTRL, 16'h0000);
        repeat (3) @(posedge aclk);
        check("phy_req", 32'h0, {31'h0, phy_req});
        wr(`PIRA_IDX_CTRL, 16'h0010);
        rchk(`PIRA_IDX_CTRL, 32'h0000);
        mute <= 1'b0;
        // Triggers only count once the machine is out of soft reset
        wr(`PIRA_IDX_CTRL, 16'h1000);
        rchk(`PIRA_IDX_CTRL, 32'h1000);
        wr(`PIRA_IDX_CTRL, 16'h1010);
        wait_done();
        check("accesses", {24'h0, c0 + 8'h01}, {24'h0, count});
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_access();
        t_busy();
        t_watchdog();
        t_irq();
        t_soft();
        finish_test();
    end

    initial
    begin
        #100000;
        errors++;
        finish_test();
    end
endmodule // phy_indirect_reg_access_test
`default_nettype wire

/* File: tb/pira_assertions.sv */
// Port checker for the PHY register bridge top.
// Bound to pira_top; watches its AXI and PHY ports only.
`timescale 1ns/10ps
`default_nettype none
module pira_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // PHY control port
    input wire logic phy_req,
    input wire logic phy_we,
    input wire logic [15:0] phy_addr,
    input wire logic [15:0] phy_wdata,
    input wire logic phy_ack
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_phy_hold;
        (phy_req && !phy_ack) ##1 phy_req |-> $stable({phy_we, phy_addr, phy_wdata});
    endproperty
    a_phy_hold: assert property (p_phy_hold) else $error("phy request changed");
    property p_ack_end;
        phy_req && phy_ack |=> !phy_req;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("request held after ack");
    // A launch only ever follows a register write
    property p_launch;
        $rose(phy_req) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_launch: assert property (p_launch) else $error("request without write");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read response dropped");
    property p_r_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("read data above 16 bits");
    property p_b_after;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer late");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read answer repeated");
endmodule // pira_assertions
bind pira_top pira_assertions i_chk (.*);
`default_nettype wire

/* File: tb/pira_phy_model.sv */
// Model of the PHY control port: 16-word store answering after a delay.
// Runs on aclk; the bench sets the delay and can silence the ack.
`timescale 1ns/10ps
`default_nettype none
module pira_phy_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench controls
    input wire logic [7:0] delay,
    input wire logic mute,
    // Control port
    input wire logic phy_req,
    input wire logic phy_we,
    input wire logic [15:0] phy_addr,
    input wire logic [15:0] phy_wdata,
    output logic phy_ack,
    output logic [15:0] phy_rdata,
    // Number of accesses served
    output logic [7:0] count
);
    logic [15:0] mem [0:15];
    logic [7:0] wait_n;
    logic served;
    always @(posedge aclk)
    begin
        phy_ack <= 1'b0;
        // Read data is only valid on the ack cycle, so it toggles otherwise
        phy_rdata <= ~phy_rdata;
        if (!aresetn)
        begin
            count <= 8'h00;
            phy_rdata <= 16'h0000;
            for (int i = 0; i < 16; i++)
                mem[i] <= 16'hA000 | 16'(i);
        end
        if (!aresetn || !phy_req)
        begin
            wait_n <= 8'h00;
            served <= 1'b0;
        end
        else if (!served && !mute)
        begin
            wait_n <= wait_n + 8'h01;
            if (wait_n == delay)
            begin
                phy_ack <= 1'b1;
                served <= 1'b1;
                count <= count + 8'h01;
                if (phy_we)
                    mem[phy_addr[3:0]] <= phy_wdata;
                else
                    phy_rdata <= mem[phy_addr[3:0]];
            end
        end
    end
endmodule // pira_phy_model
`default_nettype wire
